// ---- hw/pcc_pkg.sv ----
// Purpose: constants and types for the clock and power-mode controller
// Assumes: one 250 MHz mclk, synchronous active-low reset
// Notes:
// Contract
// - multiply reference by multiplier field plus one, 1 to 4096
// - each accepted multiplier write drops lock; relock after 2500 reference cycles
// - clocks from the multiplier are gated off while out of lock
// - reset loads multiplier field 0, 3 or 400 from the two straps
// - periodic timer clock comes straight from the reference input
// - enable bit set from supply strap at reset only, never by software
// - enable 0 takes clocks from reference, 1 from multiplier output
// - drive field 00/01/10 full, 2/3, 1/3 strength; 11 holds output high
// - drive field changes never glitch the clock output
// - multiplier register protect bit; setting write lands, later ones ignored
// - mode register has own protect bit blocking later writes
// - multiplier on: system clock from divider, else from reference
// - baud clock bypasses divider, optionally halved by baud-divide bit
// - straps sampled only in reset; frequency strap then a port line
// - mode 11 stop halts oscillator and multiplier; 70000 cycle wake
// - mode 10 stop keeps oscillator, stops multiplier; 2500 cycle wake
// - mode 01 stop only halts system clock; wake in a few clocks
// - non-zero divide field divides by two to that power, up to 15
// - zero divide field passes multiplier output undivided
// - mode register: protect 7, divide 6:3, baud-divide 2, mode 1:0
// - parked buses driven high, low or floated during stopped modes
// - mode 00 stop request causes no low-power entry
// - power-down write, 16 clocks restarted by grants, request bus, enter
// - wake event restarts clocks, releases bus, back to normal
package pcc_pkg;
  localparam logic [7:0]  PCC_OFS_MUL    = 8'hf8;
  localparam logic [7:0]  PCC_OFS_MODE   = 8'hfa;
  localparam logic [7:0]  PCC_OFS_BDRV   = 8'hfc;
  localparam logic [7:0]  PCC_OFS_STAT   = 8'hfe;
  localparam int          PCC_MUL_WP     = 15;
  localparam int          PCC_MUL_DRV_LO = 13;
  localparam int          PCC_MUL_PEN    = 12;
  localparam int          PCC_MODE_WP    = 7;
  localparam int          PCC_MODE_DF_LO = 3;
  localparam int          PCC_MODE_BAUD  = 2;
  localparam int          PCC_BDRV_EN    = 0;
  localparam int          PCC_BDRV_DLOW  = 1;
  localparam int          PCC_BDRV_ALOW  = 2;
  localparam logic [11:0] PCC_MF_OFF     = 12'h000;
  localparam logic [11:0] PCC_MF_X4      = 12'h003;
  localparam logic [11:0] PCC_MF_X401    = 12'h190;
  localparam logic [1:0]  PCC_DRV_OFF    = 2'h3;
  localparam logic [1:0]  PCC_PM_NORMAL  = 2'h0;
  localparam logic [1:0]  PCC_PM_STANDBY = 2'h1;
  localparam logic [1:0]  PCC_PM_DOZE    = 2'h2;
  localparam logic [1:0]  PCC_PM_STOP    = 2'h3;
  localparam logic [11:0] PCC_LOCK_REF   = 12'd2500;
  localparam logic [4:0]  PCC_ARM_CLKS   = 5'd16;
  localparam logic [16:0] PCC_STBY_WAKE  = 17'd3;
  typedef enum logic [4:0] {
    PCC_RUN   = 5'h01,
    PCC_ARM   = 5'h02,
    PCC_REQ   = 5'h04,
    PCC_SLEEP = 5'h08,
    PCC_WAKE  = 5'h10
  } pcc_pwr_state_type;
  typedef struct packed {
    logic [1:0] ref_s, vco_s, frq_s, sup_s, wk_s;
    logic       ref_d, vco_d;
    logic       wp_mul, multiplier_enable_bit, wp_mode, baud_div;
    logic [1:0] drive, pmode, act_drive, slp_mode;
    logic [11:0] mf, lock_cnt;
    logic [3:0] df, act_df;
    logic       bd_en, bd_dlow, bd_alow;
    logic       locked, div_out, sys_gate, sys_out;
    logic       baud_gate, baud_tgl, baud_out, clock_output_pin_out, pit_out;
    logic       port_line;
    logic [14:0] div_cnt;
    pcc_pwr_state_type fsm;
    logic [4:0] arm_cnt;
    logic [16:0] wake_cnt;
    logic [15:0] rdata;
  } pcc_state_type;
endpackage

// ---- hw/pcc_clock_power.sv ----
// Purpose: clock generation and power-mode sequencing, clocks as sampled
// Assumes: reference and multiplier output are slow pins sampled by mclk
// Notes: all output clocks are registered levels rebuilt on mclk
`timescale 1ns/1ps
module pcc_clock_power
  import pcc_pkg::*;
#(
  parameter logic [16:0] STOP_WAKE_REF = 17'd70000,
  parameter logic [16:0] DOZE_WAKE_REF = 17'd2500
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        reference_clock_in,
  input  wire logic        multiplier_oscillator_output,
  input  wire logic        frequency_strap_pin,
  input  wire logic        multiplier_supply_strap,
  input  wire logic        wake_event,
  input  wire logic        pd_write,
  input  wire logic        pd_supervisor,
  input  wire logic        irq_abort,
  input  wire logic        bus_grant,
  input  wire logic        bus_grant_ack,
  output logic             bus_request,
  output logic             osc_run,
  output logic             mult_run,
  output logic [11:0]      multiplier_field,
  output logic             sys_clk_out,
  output logic             baud_clk_out,
  output logic             pit_clk_out,
  output logic             clock_output_pin,
  output logic [1:0]       clock_out_strength,
  output logic             port_a_line_twelve,
  output logic             bus_park_oe_n,
  output logic             bus_park_addr,
  output logic             bus_park_data
);
  pcc_state_type st_reg, st_next;

  // helper terms from the registered state and the register write strobe
  logic ref_rise, vco_rise, deep, sys_src, baud_src, clk_ok;
  logic [14:0] df_mask;
  logic wr_mul, wr_mode, wr_bdrv;
  assign ref_rise = st_reg.ref_s[1] & ~st_reg.ref_d;
  assign vco_rise = st_reg.vco_s[1] & ~st_reg.vco_d;
  assign deep     = (st_reg.slp_mode == PCC_PM_STOP) |
                    (st_reg.slp_mode == PCC_PM_DOZE);
  // without the multiplier everything runs from the reference
  assign sys_src  = st_reg.multiplier_enable_bit ? st_reg.div_out : st_reg.ref_s[1];
  assign baud_src = st_reg.multiplier_enable_bit ? st_reg.vco_s[1] : st_reg.ref_s[1];
  assign clk_ok   = ~st_reg.multiplier_enable_bit | st_reg.locked;
  assign df_mask  = 15'((16'h1 << st_reg.act_df) - 16'h1);
  assign wr_mul   = reg_wr & (reg_addr == PCC_OFS_MUL);
  assign wr_mode  = reg_wr & (reg_addr == PCC_OFS_MODE);
  assign wr_bdrv  = reg_wr & (reg_addr == PCC_OFS_BDRV);

  // next-state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.ref_s = {st_reg.ref_s[0], reference_clock_in};
    st_next.vco_s = {st_reg.vco_s[0], multiplier_oscillator_output};
    st_next.frq_s = {st_reg.frq_s[0], frequency_strap_pin};
    st_next.sup_s = {st_reg.sup_s[0], multiplier_supply_strap};
    st_next.wk_s  = {st_reg.wk_s[0], wake_event};
    st_next.ref_d = st_reg.ref_s[1];
    st_next.vco_d = st_reg.vco_s[1];

    // register writes; multiplier and mode each gated by its own protect bit, bus-drive never
    if (wr_mul && !st_reg.wp_mul) begin
      st_next.wp_mul   = reg_wdata[PCC_MUL_WP];
      st_next.drive    = reg_wdata[PCC_MUL_DRV_LO +: 2];
      st_next.mf       = reg_wdata[11:0];
      st_next.locked   = 1'b0;
      st_next.lock_cnt = 12'h000;
    end
    if (wr_mode && !st_reg.wp_mode) begin
      st_next.wp_mode  = reg_wdata[PCC_MODE_WP];
      st_next.df       = reg_wdata[PCC_MODE_DF_LO +: 4];
      st_next.baud_div = reg_wdata[PCC_MODE_BAUD];
      st_next.pmode    = reg_wdata[1:0];
    end
    if (wr_bdrv) begin
      st_next.bd_en   = reg_wdata[PCC_BDRV_EN];
      st_next.bd_dlow = reg_wdata[PCC_BDRV_DLOW];
      st_next.bd_alow = reg_wdata[PCC_BDRV_ALOW];
    end

    // lock delay counted in reference ticks, held off while asleep or waking in any mode
    // a refused write must not swallow a reference tick
    if (!st_reg.locked && !(wr_mul && !st_reg.wp_mul) &&
        st_reg.fsm != PCC_SLEEP && st_reg.fsm != PCC_WAKE &&
        ref_rise) begin
      if (st_reg.lock_cnt == PCC_LOCK_REF - 12'd1) begin
        st_next.locked = 1'b1;
      end else begin
        st_next.lock_cnt = st_reg.lock_cnt + 12'd1;
      end
    end

    // power-of-two divider; ratio taken only at a period end
    if (vco_rise) begin
      if ((st_reg.div_cnt & df_mask) == df_mask) begin
        st_next.div_cnt = 15'h0000;
        st_next.act_df  = st_reg.multiplier_enable_bit ? st_reg.df : 4'h0;
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 15'h0001;
      end
    end
    if (st_reg.act_df == 4'h0) begin
      st_next.div_out = st_reg.vco_s[1];
    end else begin
      st_next.div_out = st_reg.div_cnt[st_reg.act_df - 4'h1];
    end

    // gates move only while their source is low, so no runt pulses
    // a halted multiplier may stop high, so deep sleep shuts at once
    if (!sys_src || (st_reg.fsm == PCC_SLEEP && deep)) begin
      st_next.sys_gate = clk_ok & (st_reg.fsm != PCC_SLEEP) &
                         (st_reg.fsm != PCC_WAKE);
    end
    st_next.sys_out = sys_src & st_reg.sys_gate;
    if (!baud_src || (st_reg.fsm == PCC_SLEEP && deep)) begin
      st_next.baud_gate = clk_ok & ~(deep &
        ((st_reg.fsm == PCC_SLEEP) | (st_reg.fsm == PCC_WAKE)));
    end
    // halve by toggling once per source rising edge, never on a level
    if ((st_reg.multiplier_enable_bit ? vco_rise : ref_rise) & st_reg.baud_gate &
        st_reg.baud_div) begin
      st_next.baud_tgl = ~st_reg.baud_tgl;
    end
    st_next.baud_out = st_reg.baud_div ? st_reg.baud_tgl :
                       (baud_src & st_reg.baud_gate);
    st_next.pit_out  = st_reg.ref_s[1];

    // drive code is adopted while the clock is high, so a disable lands
    // on a high level and an enable waits for the next low phase
    if (st_reg.sys_out && st_reg.clock_output_pin_out) begin
      st_next.act_drive = st_reg.drive;
    end
    st_next.clock_output_pin_out = (st_reg.act_drive == PCC_DRV_OFF) ? 1'b1 :
                       st_reg.sys_out;
    st_next.port_line = st_reg.frq_s[1];

    // power-down sequencer
    unique case (st_reg.fsm)
      PCC_RUN: begin
        if (pd_write && pd_supervisor && !irq_abort &&
            st_reg.pmode != PCC_PM_NORMAL) begin
          st_next.fsm      = PCC_ARM;
          st_next.arm_cnt  = 5'h00;
          st_next.slp_mode = st_reg.pmode;
        end
      end
      PCC_ARM: begin
        if (irq_abort || st_reg.wk_s[1]) begin
          st_next.fsm = PCC_RUN;
        end else if (bus_grant || bus_grant_ack) begin
          st_next.arm_cnt = 5'h00;
        end else if (st_reg.arm_cnt == PCC_ARM_CLKS - 5'd1) begin
          st_next.fsm = PCC_REQ;
        end else begin
          st_next.arm_cnt = st_reg.arm_cnt + 5'd1;
        end
      end
      PCC_REQ: begin
        if (irq_abort || st_reg.wk_s[1]) begin
          st_next.fsm = PCC_RUN;
        end else if (bus_grant) begin
          st_next.fsm = PCC_SLEEP;
          if (deep) begin
            st_next.locked = 1'b0;
          end
        end
      end
      PCC_SLEEP: begin
        if (st_reg.wk_s[1]) begin
          st_next.fsm      = PCC_WAKE;
          st_next.wake_cnt = 17'h00000;
        end
      end
      PCC_WAKE: begin
        if (st_reg.slp_mode == PCC_PM_STANDBY) begin
          if (st_reg.wake_cnt == PCC_STBY_WAKE - 17'd1) begin
            st_next.fsm = PCC_RUN;
          end else begin
            st_next.wake_cnt = st_reg.wake_cnt + 17'd1;
          end
        end else if (ref_rise) begin
          if (st_reg.wake_cnt == ((st_reg.slp_mode == PCC_PM_STOP) ?
              STOP_WAKE_REF : DOZE_WAKE_REF) - 17'd1) begin
            st_next.fsm    = PCC_RUN;
            st_next.locked = 1'b1;
          end else begin
            st_next.wake_cnt = st_reg.wake_cnt + 17'd1;
          end
        end
      end
    endcase

    // read data valid the cycle after the strobe; unmapped reads zero
    st_next.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        PCC_OFS_MUL:  st_next.rdata = {st_reg.wp_mul, st_reg.drive,
                                       st_reg.multiplier_enable_bit, st_reg.mf};
        PCC_OFS_MODE: st_next.rdata = {8'h00, st_reg.wp_mode, st_reg.df,
                                       st_reg.baud_div, st_reg.pmode};
        PCC_OFS_BDRV: st_next.rdata = {13'h0000, st_reg.bd_alow,
                                       st_reg.bd_dlow, st_reg.bd_en};
        PCC_OFS_STAT: st_next.rdata = {9'h000, st_reg.locked, 1'b0,
                                       st_reg.fsm};
        default:      st_next.rdata = 16'h0000;
      endcase
    end

    // synchronous reset; syncs keep sampling so straps are seen here
    if (!rst_n) begin
      st_next           = '0;
      st_next.ref_s     = {st_reg.ref_s[0], reference_clock_in};
      st_next.vco_s     = {st_reg.vco_s[0], multiplier_oscillator_output};
      st_next.frq_s     = {st_reg.frq_s[0], frequency_strap_pin};
      st_next.sup_s     = {st_reg.sup_s[0], multiplier_supply_strap};
      st_next.wk_s      = {st_reg.wk_s[0], wake_event};
      st_next.fsm       = PCC_RUN;
      st_next.clock_output_pin_out  = 1'b1;
      st_next.multiplier_enable_bit       = st_reg.sup_s[1];
      st_next.mf        = !st_reg.sup_s[1] ? PCC_MF_OFF :
                          (st_reg.frq_s[1] ? PCC_MF_X401 : PCC_MF_X4);
      st_next.locked    = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  // outputs straight from the state register
  assign reg_rdata          = st_reg.rdata;
  assign bus_request        = (st_reg.fsm == PCC_REQ) |
                              (st_reg.fsm == PCC_SLEEP) |
                              (st_reg.fsm == PCC_WAKE);
  assign osc_run            = ~((st_reg.fsm == PCC_SLEEP) &
                              (st_reg.slp_mode == PCC_PM_STOP));
  assign mult_run           = st_reg.multiplier_enable_bit & ~((st_reg.fsm == PCC_SLEEP) &
                              deep);
  assign multiplier_field   = st_reg.mf;
  assign sys_clk_out        = st_reg.sys_out;
  assign baud_clk_out       = st_reg.baud_out;
  assign pit_clk_out        = st_reg.pit_out;
  assign clock_output_pin   = st_reg.clock_output_pin_out;
  assign clock_out_strength = st_reg.act_drive;
  assign port_a_line_twelve = st_reg.port_line;
  // parking holds only while the bus is taken from the core
  assign bus_park_oe_n      = ~(st_reg.bd_en & ((st_reg.fsm == PCC_SLEEP) |
                              (st_reg.fsm == PCC_WAKE)));
  assign bus_park_addr      = ~st_reg.bd_alow;
  assign bus_park_data      = ~st_reg.bd_dlow;
endmodule // pcc_clock_power

// ---- verification/pcc_chk.sv ----
// Purpose: port checks for the clock and power controller
// Assumes: one mclk domain, synchronous active-low reset
// Notes: bound into pcc_clock_power by the bind below
`timescale 1ns/1ps
module pcc_chk
  import pcc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reference_clock_in,
  input wire logic        frequency_strap_pin,
  input wire logic        pd_write,
  input wire logic        bus_request,
  input wire logic        osc_run,
  input wire logic        sys_clk_out,
  input wire logic        pit_clk_out,
  input wire logic        clock_output_pin,
  input wire logic [1:0]  clock_out_strength,
  input wire logic        port_a_line_twelve,
  input wire logic        bus_park_oe_n
);
  logic [5:0] arm_cnt_reg;

  // cycles since a power-down write; saturates so it never wraps
  always_ff @(posedge mclk) begin
    if (!rst_n || pd_write) arm_cnt_reg <= 6'h00;
    else if (arm_cnt_reg != 6'h3f) arm_cnt_reg <= arm_cnt_reg + 6'h01;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_ref_rise; $rose(reference_clock_in); endsequence
  sequence s_pit_follow; !pit_clk_out ##[1:4] pit_clk_out; endsequence

  a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  a_pit_on_ref: assert property (s_ref_rise |-> s_pit_follow)
    else $error("timer clock not following reference");
  a_drive_off_high: assert property (clock_out_strength == PCC_DRV_OFF |-> clock_output_pin)
    else $error("disabled clock output not high");
  a_req_after_arm: assert property ($rose(bus_request) |-> arm_cnt_reg >= 6'd15)
    else $error("bus request too early");
  a_osc_sleep_only: assert property (!osc_run |-> bus_request)
    else $error("oscillator stopped outside sleep");
  a_park_sleep_only: assert property (!bus_park_oe_n |-> bus_request)
    else $error("buses parked outside sleep");
  a_stop_no_clock: assert property ((!osc_run)[*8] |-> !sys_clk_out)
    else $error("system clock running in stop");
  a_port_line_free: assert property ((frequency_strap_pin)[*5] |-> port_a_line_twelve)
    else $error("port line not following strap pin");
endmodule // pcc_chk

bind pcc_clock_power pcc_chk u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reference_clock_in(reference_clock_in),
  .frequency_strap_pin(frequency_strap_pin), .pd_write(pd_write),
  .bus_request(bus_request), .osc_run(osc_run), .sys_clk_out(sys_clk_out),
  .pit_clk_out(pit_clk_out), .clock_output_pin(clock_output_pin),
  .clock_out_strength(clock_out_strength),
  .port_a_line_twelve(port_a_line_twelve), .bus_park_oe_n(bus_park_oe_n)
);

// ---- verification/pcc_core_model.sv ----
// Purpose: core side model: crystal, multiplier output, bus grant
// Assumes: slow clocks toggled on mclk edges
// Notes: grant delay set by the bench, prompt or slow
`timescale 1ns/1ps
module pcc_core_model #(
  parameter int REF_HALF = 4,
  parameter int VCO_HALF = 4
) (
  input  wire logic       mclk,
  input  wire logic       osc_run,
  input  wire logic       mult_run,
  input  wire logic       bus_request,
  input  wire logic [2:0] grant_delay,
  output logic            reference_clock_in,
  output logic            multiplier_oscillator_output,
  output logic            bus_grant
);
  int ref_cnt = 0;
  int vco_cnt = 0;
  int gnt_cnt = 0;

  initial {reference_clock_in, multiplier_oscillator_output, bus_grant} = 3'h0;
  // halted sources stand still, never kinder than silicon
  always @(posedge mclk) begin
    ref_cnt = (osc_run === 1'b1) ? (ref_cnt + 1) % REF_HALF : 1;
    vco_cnt = (mult_run === 1'b1) ? (vco_cnt + 1) % VCO_HALF : 1;
    gnt_cnt = (bus_request === 1'b1) ? gnt_cnt + 1 : 0;
    if (ref_cnt == 0) reference_clock_in <= !reference_clock_in;
    if (vco_cnt == 0) multiplier_oscillator_output <= !multiplier_oscillator_output;
    bus_grant <= (gnt_cnt > int'(grant_delay));
  end
endmodule // pcc_core_model

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the clock and power controller
// Assumes: core model makes reference, multiplier output and grants
// Notes: short wake counts keep the sleep tests brief
`timescale 1ns/1ps
module tb_top
  import pcc_pkg::*;
;
  localparam int REF_TICK = 8;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        freq_strap = 1'b1;
  logic        wake_event = 1'b0;
  logic        pd_write = 1'b0;
  logic        pd_super = 1'b1;
  logic        irq_abort = 1'b0;
  logic [2:0]  grant_delay = 3'h0;
  logic [15:0] reg_rdata, rd_val;
  logic [11:0] multiplier_field, mf;
  logic [7:0]  mode_b;
  logic [1:0]  strength;
  logic        ref_clk, vco_out, bus_grant, bus_request, osc_run, mult_run;
  logic        sys_clk, baud_clk, pit_clk, clk_out_pin, port_line;
  logic        park_oe_n, park_addr, park_data;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0, sys_t = 0, sys_per = 0, baud_t = 0, baud_per = 0, n;

  initial forever #2 mclk = ~mclk;
  // cycle count and last measured periods of the rebuilt clocks
  always @(posedge mclk) cyc++;
  always @(posedge sys_clk) {sys_per, sys_t} = {cyc - sys_t, cyc};
  always @(posedge baud_clk) {baud_per, baud_t} = {cyc - baud_t, cyc};

  pcc_clock_power #(.STOP_WAKE_REF(17'd5), .DOZE_WAKE_REF(17'd4)) DUT (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reference_clock_in(ref_clk), .multiplier_oscillator_output(vco_out),
    .frequency_strap_pin(freq_strap), .multiplier_supply_strap(1'b1),
    .wake_event(wake_event), .pd_write(pd_write), .pd_supervisor(pd_super),
    .irq_abort(irq_abort), .bus_grant(bus_grant), .bus_grant_ack(1'b0),
    .bus_request(bus_request), .osc_run(osc_run), .mult_run(mult_run),
    .multiplier_field(multiplier_field), .sys_clk_out(sys_clk),
    .baud_clk_out(baud_clk), .pit_clk_out(pit_clk),
    .clock_output_pin(clk_out_pin), .clock_out_strength(strength),
    .port_a_line_twelve(port_line), .bus_park_oe_n(park_oe_n),
    .bus_park_addr(park_addr), .bus_park_data(park_data));
  pcc_core_model #(.REF_HALF(REF_TICK / 2), .VCO_HALF(REF_TICK / 2)) u_core (
    .mclk(mclk), .osc_run(osc_run), .mult_run(mult_run),
    .bus_request(bus_request), .grant_delay(grant_delay),
    .reference_clock_in(ref_clk), .multiplier_oscillator_output(vco_out),
    .bus_grant(bus_grant));

  task automatic chk(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // poll the lock flag; n is the span since t0
  task automatic wait_lock(input int t0);
    rd_val = 16'h0000;
    while (rd_val[6] !== 1'b1 && cyc - t0 < 30000) rd(PCC_OFS_STAT);
    n = cyc - t0;
  endtask
  task automatic wait_req(input logic want, input int limit);
    for (n = 0; bus_request !== want && n < limit; n++) tick(1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    void'($urandom(34));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(PCC_OFS_MUL);
    chk("mul_reset", rd_val, 16'h1190);
    chk("mf_port", multiplier_field, PCC_MF_X401);
    rd(8'h10);
    chk("unmapped", rd_val, 16'h0000);
    wait_lock(0);
    chk("first_lock", rd_val[6], 1'b1);
    @(posedge mclk) freq_strap <= 1'b0;
    tick(8);
    chk("port_line", port_line, 1'b0);
    rd(PCC_OFS_MUL);
    chk("strap_ignored", rd_val, 16'h1190);
    $display("reset test done");
    repeat (3) begin
      mode_b = 8'($urandom) & 8'h0f;
      wr(PCC_OFS_MODE, {8'($urandom), mode_b});
      rd(PCC_OFS_MODE);
      chk("mode_rw", rd_val, {8'h00, mode_b});
    end
    // divide factor sets system period; baud clock skips the divider
    for (int d = 0; d < 3; d++) begin
      wr(PCC_OFS_MODE, 16'((d << 3) | ((d & 1) << 2)));
      tick(40 << d);
      chk("sys_period", sys_per, REF_TICK << d);
      chk("baud_period", baud_per, REF_TICK << (d & 1));
    end
    $display("divider test done");
    wr(PCC_OFS_BDRV, 16'h0003);
    for (int m = 0; m < 4; m++) begin
      wr(PCC_OFS_MODE, 16'(m));
      grant_delay <= 3'($urandom);
      @(posedge mclk) pd_write <= 1'b1;
      @(posedge mclk) pd_write <= 1'b0;
      wait_req(1'b1, 40);
      chk("req_delay", n, (m == 0) ? 40 : 16);
      if (m != 0) begin
        tick(20);
        chk("osc_run", osc_run, m != 3);
        chk("mult_run", mult_run, m == 1);
        chk("sys_gated", sys_clk, 1'b0);
        chk("park", {park_oe_n, park_addr, park_data}, 3'b010);
        @(posedge mclk) wake_event <= 1'b1;
        wait_req(1'b0, 300);
        @(posedge mclk) wake_event <= 1'b0;
        chk("woke", bus_request, 1'b0);
        rd(PCC_OFS_STAT);
        chk("relocked", rd_val[6], 1'b1);
      end
    end
    // user-mode write, then an abort beside the write: both refused
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) {pd_write, pd_super, irq_abort} <= {1'b1, 1'(k), 1'(k)};
      @(posedge mclk) {pd_write, pd_super, irq_abort} <= 3'b010;
      wait_req(1'b1, 40);
      chk("pd_refused", n, 40);
    end
    $display("power mode test done");
    mf = 12'($urandom);
    wr(PCC_OFS_MUL, {4'he, mf});
    n = cyc;
    wr(PCC_OFS_MUL, {4'h1, ~mf});
    rd(PCC_OFS_MUL);
    chk("mul_protect", rd_val, {4'hf, mf});
    chk("mf_port", multiplier_field, mf);
    tick(6);
    chk("sys_unlocked", sys_clk, 1'b0);
    wait_lock(n);
    chk("relock_span", n >= 19985 && n <= 20015, 1'b1);
    tick(16);
    chk("clock_output_pin_off", {strength, clk_out_pin}, 3'b111);
    $display("multiplier test done");
    wr(PCC_OFS_MODE, 16'h0081);
    wr(PCC_OFS_MODE, 16'h0002);
    rd(PCC_OFS_MODE);
    chk("mode_protect", rd_val, 16'h0081);
    $display("protect test done");
    tally_and_finish();
  end

  // cut a hang short; the run needs about 41000 cycles
  initial begin
    #(4 * 80000);
    mismatches++;
    tally_and_finish();
  end
endmodule // tb_top
